// [hdl/rtc_core_pkg.sv]
// shared constants and carrier types for the bcd timekeeper
package rtc_core_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] ADDR_FRACTION_SECONDS = 6'h00;
  localparam logic [5:0] ADDR_SECONDS_STOP = 6'h01;
  localparam logic [5:0] ADDR_MINUTES = 6'h02;
  localparam logic [5:0] ADDR_CENTURY_AND_HOURS = 6'h03;
  localparam logic [5:0] ADDR_WEEKDAY = 6'h04;
  localparam logic [5:0] ADDR_DAY_OF_MONTH = 6'h05;
  localparam logic [5:0] ADDR_MONTH = 6'h06;
  localparam logic [5:0] ADDR_YEAR = 6'h07;
  localparam logic [5:0] ADDR_OUTPUT_AND_CALIBRATION = 6'h08;
  localparam logic [5:0] ADDR_WATCHDOG_CONFIG = 6'h09;
  localparam logic [5:0] ADDR_ALARM_MONTH_ENABLES = 6'h0A;
  localparam logic [5:0] ADDR_ALARM_DAY_OF_MONTH = 6'h0B;
  localparam logic [5:0] ADDR_ALARM_HOUR_HALT = 6'h0C;
  localparam logic [5:0] ADDR_ALARM_MINUTE = 6'h0D;
  localparam logic [5:0] ADDR_ALARM_SECOND = 6'h0E;
  localparam logic [5:0] ADDR_EVENT_FLAGS = 6'h0F;
  localparam logic [5:0] ADDR_RESERVED_A = 6'h10;
  localparam logic [5:0] ADDR_RESERVED_C = 6'h12;
  localparam logic [5:0] ADDR_SQUARE_WAVE_RATE = 6'h13;
  localparam logic [5:0] ADDR_FIRST_NON_CLOCK = 6'h08;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int OSCILLATOR_HALT_BIT = 7;
  localparam int CENTURY_TOGGLE_ENABLE_BIT = 7;
  localparam int CENTURY_FLAG_BIT = 6;
  localparam int UPDATE_FREEZE_BIT = 6;
  localparam int ALARM_IRQ_ENABLE_BIT = 7;
  localparam int BACKUP_ALARM_ENABLE_BIT = 5;
  localparam int REPEAT_HI_BIT = 7;
  localparam int REPEAT_BIT_5_BIT = 6;
  localparam int CMD_WRITE_BIT = 7;

  // ----------------------------------------------------------------
  // values after reset and fixed codes
  // ----------------------------------------------------------------
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] RESET_ONE_BCD = 8'h01;
  localparam logic [4:0] RPT_EVERY_SECOND = 5'h1F;
  localparam logic [4:0] RPT_EVERY_MINUTE = 5'h1E;
  localparam logic [4:0] RPT_EVERY_HOUR = 5'h1C;
  localparam logic [4:0] RPT_EVERY_DAY = 5'h18;
  localparam logic [4:0] RPT_EVERY_MONTH = 5'h10;
  localparam logic [4:0] RPT_EVERY_YEAR = 5'h00;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int HUNDREDTH_PERIOD_MS = 10;
  // divide first so the product stays inside a 32-bit int
  localparam int HUNDREDTH_CYCLES = HUNDREDTH_PERIOD_MS * (1000000000 / CLK_PERIOD_PS);

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic scl;
    logic chip_enable_b;
    logic sdi;
    logic power_fail;
    logic low_battery_flag;
  } pin_set_t;

  typedef struct packed {
    logic valid;
    logic [5:0] addr;
    logic [7:0] data;
  } host_write_t;

endpackage : rtc_core_pkg

// [hdl/bcd_timekeeper_alarm.sv]
// bcd timekeeper with repeat alarm behind an spi slave port
// How it works
// - eight bcd clock registers at 00h-07h, host readable and writable.
// - century flag inverts at century rollover only when century toggle enable set.
// - weekday low three bits count one through seven.
// - oscillator halt bit stops counting; clearing resumes within one second.
// - reading clock addresses freezes user-copy refresh.
// - power failure sets update freeze; clearing it resumes refresh.
// - user copies refreshed together from internal counters.
// - completed host write to a clock address resets the divider chain.
// - writing clock addresses freezes refresh until deselect or pointer leaves them.
// - clock and alarm bytes are bcd, control bytes plain binary.
// - alarm match sets alarm hit flag; with irq enable drives interrupt pin.
// - repeat bits select second, minute, hour, day, month or year matching.
// - undefined repeat codes fire every second.
// - pointer resting on flags address withholds alarm flag and interrupt.
// - reading flags clears alarm hit flag and interrupt pin.
// - in battery backup interrupt needs both backup and irq enables.
// - power-up clears backup alarm enable and alarm irq enable.
// - control register reachable on its own, independent of clock registers.
// - first spi bit one writes, zero reads; one unused bit, then six address bits; then data.
// - burst pointer increments per byte, wrapping 3Fh to 00h.
module bcd_timekeeper_alarm
  import rtc_core_pkg::*;
#(
  parameter int HUNDREDTH_CYCLES_P = rtc_core_pkg::HUNDREDTH_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic scl_i,
  input wire logic chip_enable_b_i,
  input wire logic sdi_i,
  input wire logic power_fail_i,
  input wire logic low_battery_flag_i,
  output logic sdo_o,
  output logic sdo_oe_b_o,
  output logic interrupt_output_pin_o,
  output logic interrupt_output_pin_oe_b_o
);
  import rtc_core_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  pin_set_t pins_meta;
  pin_set_t pins;
  pin_set_t pins_prev;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pins_meta <= '{scl: 1'b0, chip_enable_b: 1'b1, sdi: 1'b0, power_fail: 1'b0,
                     low_battery_flag: 1'b0};
      pins <= '{scl: 1'b0, chip_enable_b: 1'b1, sdi: 1'b0, power_fail: 1'b0,
                low_battery_flag: 1'b0};
      pins_prev <= '{scl: 1'b0, chip_enable_b: 1'b1, sdi: 1'b0, power_fail: 1'b0,
                     low_battery_flag: 1'b0};
    end else begin
      pins_meta <= '{scl: scl_i, chip_enable_b: chip_enable_b_i, sdi: sdi_i,
                     power_fail: power_fail_i, low_battery_flag: low_battery_flag_i};
      pins <= pins_meta;
      pins_prev <= pins;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic selected;
  logic power_lost;
  logic power_back;
  assign selected = !pins.chip_enable_b && !pins.power_fail;
  assign scl_rise = pins.scl && !pins_prev.scl;
  assign scl_fall = !pins.scl && pins_prev.scl;
  assign power_lost = pins.power_fail && !pins_prev.power_fail;
  assign power_back = !pins.power_fail && pins_prev.power_fail;

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [7:0] itime [0:7];
  logic [7:0] ucopy [0:7];
  logic [7:0] regs [8:63];
  logic alarm_hit_flag;
  logic [7:0] read_byte;
  logic [5:0] read_addr;

  // ----------------------------------------------------------------
  // spi slave, modes 0 and 3
  // ----------------------------------------------------------------
  logic addr_phase;
  logic is_write;
  logic [2:0] bit_cnt;
  logic [5:0] ptr;
  logic [7:0] shift_in;
  logic [7:0] shift_out;
  logic [7:0] next_byte;
  logic byte_done;
  logic flags_read;
  host_write_t host_wr;

  assign next_byte = {shift_in[6:0], pins.sdi};
  assign byte_done = selected && scl_rise && (bit_cnt == 3'h7);
  assign read_addr = addr_phase ? next_byte[5:0] : 6'(ptr + 6'h01);

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      addr_phase <= 1'b1;
      is_write <= 1'b0;
      bit_cnt <= 3'h0;
      ptr <= 6'h00;
      shift_in <= RESET_BYTE;
      shift_out <= RESET_BYTE;
      flags_read <= 1'b0;
      host_wr <= '0;
    end else begin
      flags_read <= 1'b0;
      host_wr.valid <= 1'b0;
      if (!selected) begin
        addr_phase <= 1'b1;
        bit_cnt <= 3'h0;
        if (pins.power_fail) begin
          ptr <= 6'h00;
        end
      end else if (scl_rise) begin
        shift_in <= next_byte;
        bit_cnt <= 3'(bit_cnt + 3'h1);
        if (bit_cnt == 3'h7) begin
          if (addr_phase) begin
            addr_phase <= 1'b0;
            is_write <= next_byte[CMD_WRITE_BIT];
            ptr <= next_byte[5:0];
            if (!next_byte[CMD_WRITE_BIT]) begin
              shift_out <= read_byte;
              flags_read <= (next_byte[5:0] == ADDR_EVENT_FLAGS);
            end
          end else begin
            ptr <= 6'(ptr + 6'h01);
            if (is_write) begin
              host_wr <= '{valid: 1'b1, addr: ptr, data: next_byte};
            end else begin
              shift_out <= read_byte;
              flags_read <= (read_addr == ADDR_EVENT_FLAGS);
            end
          end
        end
      end else if (scl_fall && !addr_phase && !is_write) begin
        shift_out <= {shift_out[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sdo_o <= 1'b0;
      sdo_oe_b_o <= 1'b1;
    end else begin
      sdo_oe_b_o <= !(selected && !addr_phase && !is_write);
      if (selected && scl_fall && !addr_phase && !is_write) begin
        sdo_o <= shift_out[7];
      end
    end
  end

  // user copies stay put while a clock address is the live target
  logic clock_access;
  logic refresh_hold;
  assign clock_access = selected && !addr_phase && (ptr < ADDR_FIRST_NON_CLOCK);
  assign refresh_hold = clock_access || regs[ADDR_ALARM_HOUR_HALT][UPDATE_FREEZE_BIT];

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    if (read_addr < ADDR_FIRST_NON_CLOCK) begin
      read_byte = ucopy[read_addr[2:0]];
    end else if (read_addr == ADDR_EVENT_FLAGS) begin
      read_byte = {1'b0, alarm_hit_flag, 1'b0, pins.low_battery_flag, 4'h0};
    end else if (read_addr >= ADDR_RESERVED_A && read_addr <= ADDR_RESERVED_C) begin
      read_byte = RESET_BYTE;
    end else begin
      read_byte = regs[read_addr];
    end
  end

  // ----------------------------------------------------------------
  // bcd counting chain
  // ----------------------------------------------------------------
  function automatic logic [7:0] bcd_step(input logic [7:0] v, input logic [7:0] lo,
                                          input logic [7:0] hi);
    logic [7:0] r;
    r = lo;
    if (v < hi) begin
      r = (v[3:0] >= 4'h9) ? {4'(v[7:4] + 4'h1), 4'h0} : 8'(v + 8'h01);
    end
    return r;
  endfunction

  function automatic logic [7:0] month_last_day(input logic [4:0] m, input logic [7:0] y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    case (m)
      5'h02: month_last_day = leap ? 8'h29 : 8'h28;
      5'h04, 5'h06, 5'h09, 5'h11: month_last_day = 8'h30;
      default: month_last_day = 8'h31;
    endcase
  endfunction

  logic [7:0] next_t [0:7];
  logic [7:0] step;
  logic second_wrap;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      next_t[i] = itime[i];
    end
    step = RESET_BYTE;
    next_t[0] = bcd_step(itime[0], 8'h00, 8'h99);
    second_wrap = (itime[0] >= 8'h99);
    if (second_wrap) begin
      step = bcd_step({1'b0, itime[1][6:0]}, 8'h00, 8'h59);
      next_t[1][6:0] = step[6:0];
      if (itime[1][6:0] >= 7'h59) begin
        step = bcd_step({1'b0, itime[2][6:0]}, 8'h00, 8'h59);
        next_t[2][6:0] = step[6:0];
        if (itime[2][6:0] >= 7'h59) begin
          step = bcd_step({2'b00, itime[3][5:0]}, 8'h00, 8'h23);
          next_t[3][5:0] = step[5:0];
          if (itime[3][5:0] >= 6'h23) begin
            step = bcd_step({5'h00, itime[4][2:0]}, 8'h01, 8'h07);
            next_t[4][2:0] = step[2:0];
            step = bcd_step({2'b00, itime[5][5:0]}, 8'h01,
                            month_last_day(itime[6][4:0], itime[7]));
            next_t[5][5:0] = step[5:0];
            if (step == 8'h01) begin
              step = bcd_step({3'b000, itime[6][4:0]}, 8'h01, 8'h12);
              next_t[6][4:0] = step[4:0];
              if (step == 8'h01) begin
                next_t[7] = bcd_step(itime[7], 8'h00, 8'h99);
                if (itime[7] >= 8'h99 && itime[3][CENTURY_TOGGLE_ENABLE_BIT]) begin
                  next_t[3][CENTURY_FLAG_BIT] = !itime[3][CENTURY_FLAG_BIT];
                end
              end
            end
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // divider and internal counters
  // ----------------------------------------------------------------
  logic [31:0] div_cnt;
  logic tick;
  logic clock_written;
  logic second_done;
  assign clock_written = host_wr.valid && (host_wr.addr < ADDR_FIRST_NON_CLOCK);
  assign tick = (div_cnt == 32'(HUNDREDTH_CYCLES_P - 1));

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_cnt <= 32'h0;
      second_done <= 1'b0;
      for (int i = 0; i < 8; i++) begin
        itime[i] <= (i >= 4 && i <= 6) ? RESET_ONE_BCD : RESET_BYTE;
      end
    end else begin
      second_done <= 1'b0;
      if (clock_written) begin
        div_cnt <= 32'h0;
        itime[host_wr.addr[2:0]] <= host_wr.data;
      end else if (itime[1][OSCILLATOR_HALT_BIT]) begin
        div_cnt <= 32'h0;
      end else if (tick) begin
        div_cnt <= 32'h0;
        second_done <= second_wrap;
        for (int i = 0; i < 8; i++) begin
          itime[i] <= next_t[i];
        end
      end else begin
        div_cnt <= 32'(div_cnt + 32'h1);
      end
    end
  end

  // ----------------------------------------------------------------
  // register file and user copies
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < 8; i++) begin
        ucopy[i] <= (i >= 4 && i <= 6) ? RESET_ONE_BCD : RESET_BYTE;
      end
      for (int i = 8; i < 64; i++) begin
        regs[i] <= RESET_BYTE;
      end
    end else begin
      if (clock_written) begin
        ucopy[host_wr.addr[2:0]] <= host_wr.data;
      end else if (!refresh_hold) begin
        for (int i = 0; i < 8; i++) begin
          ucopy[i] <= itime[i];
        end
      end
      if (host_wr.valid && host_wr.addr >= ADDR_FIRST_NON_CLOCK) begin
        if (host_wr.addr == ADDR_SQUARE_WAVE_RATE) begin
          regs[host_wr.addr] <= {host_wr.data[7:4], 4'h0};
        end else if (host_wr.addr < ADDR_EVENT_FLAGS || host_wr.addr > ADDR_RESERVED_C) begin
          regs[host_wr.addr] <= host_wr.data;
        end
      end
      if (power_lost) begin
        regs[ADDR_ALARM_HOUR_HALT][UPDATE_FREEZE_BIT] <= 1'b1;
      end
      if (power_back) begin
        regs[ADDR_ALARM_MONTH_ENABLES][ALARM_IRQ_ENABLE_BIT] <= 1'b0;
        regs[ADDR_ALARM_MONTH_ENABLES][BACKUP_ALARM_ENABLE_BIT] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // alarm match and interrupt
  // ----------------------------------------------------------------
  logic [4:0] repeat_code;
  logic sec_eq, min_eq, hour_eq, date_eq, month_eq;
  logic alarm_match;
  logic alarm_pending;
  logic alarm_fire;
  logic irq_enable;
  logic backup_enable;
  logic irq_on;

  assign repeat_code = {regs[ADDR_ALARM_DAY_OF_MONTH][REPEAT_BIT_5_BIT],
                        regs[ADDR_ALARM_DAY_OF_MONTH][REPEAT_HI_BIT],
                        regs[ADDR_ALARM_HOUR_HALT][REPEAT_HI_BIT],
                        regs[ADDR_ALARM_MINUTE][REPEAT_HI_BIT],
                        regs[ADDR_ALARM_SECOND][REPEAT_HI_BIT]};
  assign sec_eq = itime[1][6:0] == regs[ADDR_ALARM_SECOND][6:0];
  assign min_eq = itime[2][6:0] == regs[ADDR_ALARM_MINUTE][6:0];
  assign hour_eq = itime[3][5:0] == regs[ADDR_ALARM_HOUR_HALT][5:0];
  assign date_eq = itime[5][5:0] == regs[ADDR_ALARM_DAY_OF_MONTH][5:0];
  assign month_eq = itime[6][4:0] == regs[ADDR_ALARM_MONTH_ENABLES][4:0];
  assign irq_enable = regs[ADDR_ALARM_MONTH_ENABLES][ALARM_IRQ_ENABLE_BIT];
  assign backup_enable = regs[ADDR_ALARM_MONTH_ENABLES][BACKUP_ALARM_ENABLE_BIT];

  always_comb begin
    case (repeat_code)
      RPT_EVERY_SECOND: alarm_match = 1'b1;
      RPT_EVERY_MINUTE: alarm_match = sec_eq;
      RPT_EVERY_HOUR: alarm_match = sec_eq && min_eq;
      RPT_EVERY_DAY: alarm_match = sec_eq && min_eq && hour_eq;
      RPT_EVERY_MONTH: alarm_match = sec_eq && min_eq && hour_eq && date_eq;
      RPT_EVERY_YEAR: alarm_match = sec_eq && min_eq && hour_eq && date_eq && month_eq;
      default: alarm_match = 1'b1;
    endcase
  end

  // a match seen while the pointer sits on flags waits for it to move away
  assign alarm_fire = (alarm_pending || (second_done && alarm_match))
                      && (ptr != ADDR_EVENT_FLAGS);

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      alarm_pending <= 1'b0;
    end else if (ptr == ADDR_EVENT_FLAGS) begin
      alarm_pending <= alarm_pending || (second_done && alarm_match);
    end else begin
      alarm_pending <= 1'b0;
    end
  end

  // clear wins when a match lands on the flags read; the match waits in alarm_pending
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      alarm_hit_flag <= 1'b0;
    end else if (alarm_fire) begin
      alarm_hit_flag <= 1'b1;
    end else if (flags_read) begin
      alarm_hit_flag <= 1'b0;
    end
  end

  assign irq_on = alarm_hit_flag && irq_enable && (!pins.power_fail || backup_enable);

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      interrupt_output_pin_o <= 1'b0;
      interrupt_output_pin_oe_b_o <= 1'b1;
    end else begin
      interrupt_output_pin_o <= 1'b0;
      interrupt_output_pin_oe_b_o <= !irq_on;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  ptr_burst_step_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (byte_done && !addr_phase) |=> (ptr == 6'($past(ptr) + 6'h01)))
    else $error("pointer did not advance after a data byte");

  copy_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (clock_access && !clock_written) |=> (ucopy[0] == $past(ucopy[0])))
    else $error("user copy changed during clock access");

  flag_clear_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (flags_read && !alarm_fire) |=> !alarm_hit_flag)
    else $error("alarm flag survived a flags read");

  flag_withheld_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    $rose(alarm_hit_flag) |-> ($past(ptr) != ADDR_EVENT_FLAGS))
    else $error("alarm flag rose with pointer on flags");

  irq_gate_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (!interrupt_output_pin_oe_b_o) |-> $past(alarm_hit_flag && irq_enable
                                   && (!pins.power_fail || backup_enable)))
    else $error("interrupt driven without its enables");

  div_reset_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    clock_written |=> (div_cnt == 32'h0) ##1 (div_cnt <= 32'h1))
    else $error("divider not restarted by clock write");

  halt_freeze_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (itime[1][OSCILLATOR_HALT_BIT] && !clock_written) |=> $stable(itime[0]))
    else $error("hundredths moved while halted");

  power_freeze_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    power_lost |=> regs[ADDR_ALARM_HOUR_HALT][UPDATE_FREEZE_BIT])
    else $error("update freeze not set on power loss");

  powerup_clear_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    power_back |=> !irq_enable && !backup_enable)
    else $error("alarm enables not cleared at power-up");

endmodule // bcd_timekeeper_alarm

// [tb/spi_host_model.sv]
// host-side spi master model for the timekeeper serial port
module spi_host_model (
  input wire logic clk_sys_i,
  input wire logic sdo_i,
  input wire logic sdo_oe_b_i,
  output logic scl_o,
  output logic chip_enable_b_o,
  output logic sdi_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // half scl period in system clocks; the bench varies it
  int half = 8;
  initial begin
    scl_o = 1'b0;
    chip_enable_b_o = 1'b1;
    sdi_o = 1'b0;
  end
  task automatic ticks(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  // mode 0: data set on fall, both sides sample on rise
  task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sdi_o <= tx[i];
      ticks(half);
      scl_o <= 1'b1;
      rx[i] = sdo_oe_b_i ? 1'bx : sdo_i;
      ticks(half);
      scl_o <= 1'b0;
    end
  endtask
  task automatic frame(input logic wr, input logic [5:0] a, input int n, inout logic [7:0] d[8]);
    logic [7:0] rx;
    chip_enable_b_o <= 1'b0;
    ticks(half);
    shift({wr, 1'b0, a}, rx);
    for (int k = 0; k < n; k++) shift(d[k], d[k]);
    ticks(half);
    chip_enable_b_o <= 1'b1;
    // released line must not keep showing the last bit
    sdi_o <= ~sdi_o;
    ticks(2 * half);
  endtask
endmodule // spi_host_model

// [tb/bcd_timekeeper_alarm_tb.sv]
// self-checking bench for the bcd timekeeper with alarm
module bcd_timekeeper_alarm_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rtc_core_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_b_i, power_fail_i, low_battery_flag_i, scl, ce_b, sdi, sdo, sdo_oe_b, irq, irq_oe_b;
  logic [16:0] seed = 17'h10FEF;
  logic [7:0] d [8];
  logic [7:0] exp [8];
  logic [4:0] codes [10] = '{5'h1F, 5'h1E, 5'h1C, 5'h18, 5'h10, 5'h00, 5'h0B, 5'h00, 5'h10, 5'h00};
  int mode [10] = '{0, 0, 0, 0, 0, 0, 0, 1, 1, 2};
  logic fire [10] = '{1, 1, 0, 0, 0, 0, 1, 1, 1, 0};
  int bad_count = 0;
  int comparisons = 0;
  always #2.5 clk_sys_i = ~clk_sys_i;
  bcd_timekeeper_alarm #(.HUNDREDTH_CYCLES_P(20)) bcd_timekeeper_alarm_i (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .scl_i(scl), .chip_enable_b_i(ce_b),
    .sdi_i(sdi), .power_fail_i(power_fail_i), .low_battery_flag_i(low_battery_flag_i),
    .sdo_o(sdo), .sdo_oe_b_o(sdo_oe_b), .interrupt_output_pin_o(irq),
    .interrupt_output_pin_oe_b_o(irq_oe_b));
  spi_host_model spi_host_model_i (.clk_sys_i(clk_sys_i), .sdo_i(sdo),
    .sdo_oe_b_i(sdo_oe_b), .scl_o(scl), .chip_enable_b_o(ce_b), .sdi_o(sdi));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic int pick(input int n);
    seed = {seed[15:0], seed[16] ^ seed[13]};
    return int'(seed % 17'(n));
  endfunction
  function automatic logic [7:0] bcd(input int v);
    return 8'((v / 10) * 16 + v % 10);
  endfunction
  task automatic check8(input string what, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic check_pin(input string what, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %b seen %b", what, e, g);
    end
  endtask
  task automatic wr(input logic [5:0] a, input int n);
    spi_host_model_i.frame(1'b1, a, n, d);
  endtask
  task automatic rd(input logic [5:0] a, input int n);
    spi_host_model_i.frame(1'b0, a, n, d);
  endtask
  // stop first so later bytes of a burst cannot carry
  task automatic stop_clock();
    d[0] = 8'h80;
    wr(6'h01, 1);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    logic [4:0] c;
    logic [7:0] ctl;
    logic lb;
    int m;
    rst_b_i = 1'b0;
    power_fail_i = 1'b0;
    low_battery_flag_i = 1'b0;
    repeat (5) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    for (int t = 0; t < 3; t++) begin
      stop_clock();
      exp = '{bcd(pick(100)), 8'h80 | bcd(pick(60)), bcd(pick(60)), bcd(pick(24)),
        8'(pick(7) + 1), bcd(pick(28) + 1), bcd(pick(12) + 1), bcd(pick(100))};
      d = exp;
      wr(6'h00, 8);
      rd(6'h00, 8);
      for (int k = 0; k < 8; k++) check8("clock byte", exp[k], d[k]);
      $display("stopped time case %0d done", t);
    end
    for (int i = 0; i < 10; i++) begin
      spi_host_model_i.half = 5 + 7 * i[0];
      m = mode[i];
      c = codes[i];
      stop_clock();
      d = '{8'h99, 8'hD9, 8'h59, {i[0], 7'h23}, 8'h07, 8'h31, 8'h12, 8'h99};
      wr(6'h00, 8);
      d[0] = m == 0 ? 8'h85 : 8'h81;
      d[1] = {c[3], c[4], m == 0 ? 6'h15 : (m == 1 ? 6'h01 : 6'h00)};
      d[2] = {c[2], 1'b0, m == 0 ? 6'h12 : 6'h00};
      d[3] = {c[1], m == 0 ? 7'h30 : 7'h00};
      d[4] = {c[0], 7'h00};
      wr(6'h0A, 5);
      ctl = 8'(pick(256));
      d[0] = ctl;
      wr(6'h08, 1);
      rd(6'h08, 1);
      check8("control", ctl, d[0]);
      lb = 1'(pick(2));
      low_battery_flag_i <= lb;
      d[0] = 8'h59;
      wr(6'h01, 1);
      repeat (400) @(posedge clk_sys_i);
      check_pin("irq", ~fire[i], irq_oe_b);
      check_pin("irq level", 1'b0, irq);
      rd(6'h0F, 1);
      check8("flags", {1'b0, fire[i], 1'b0, lb, 4'h0}, d[0]);
      check_pin("irq cleared", 1'b1, irq_oe_b);
      rd(6'h01, 7);
      exp = '{8'h00, 8'h00, {i[0], i[0], 6'h00}, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00};
      for (int k = 0; k < 7; k++) check8("rolled time", exp[k], d[k]);
      $display("alarm case %0d done", i);
    end
    power_fail_i <= 1'b1;
    repeat (20) @(posedge clk_sys_i);
    power_fail_i <= 1'b0;
    repeat (20) @(posedge clk_sys_i);
    rd(6'h0A, 3);
    check8("enables", 8'h00, d[0] & 8'hA0);
    check8("freeze", 8'h40, d[2] & 8'h40);
    $display("power cycle done");
    results();
  end
  initial begin
    #500000;
    bad_count++;
    $display("ERROR watchdog expected finish seen hang");
    results();
  end
endmodule // bcd_timekeeper_alarm_tb
